// file: verilog/adcc_cfg.svh
// register offsets, field positions, reset values and timing counts
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH
`define ADCC_OFF_RES_HIGH 12'h000
`define ADCC_OFF_RES_LOW 12'h004
`define ADCC_OFF_CTRL0 12'h008
`define ADCC_OFF_PORT_CFG 12'h00c
`define ADCC_OFF_TIMING_CFG 12'h010
`define ADCC_OFF_IRQ_STATUS 12'h014
`define ADCC_OFF_IRQ_MASK 12'h018
`define ADCC_CTRL0_RESET 8'h00
`define ADCC_PORT_CFG_RESET 8'h00
`define ADCC_TIMING_CFG_RESET 8'h00
`define ADCC_BIT_ENABLE 0
`define ADCC_BIT_GO 1
`define ADCC_CHS_LSB 2
`define ADCC_CHS_MSB 5
`define ADCC_TIMING_JUSTIFY 7
`define ADCC_TIMING_ACQ_MSB 5
`define ADCC_TIMING_ACQ_LSB 3
`define ADCC_TIMING_CLK_MSB 2
`define ADCC_TIMING_CLK_LSB 0
`define ADCC_CHAN_LAST 4'ha
`define ADCC_SMALL_GAP_LO 4'h5
`define ADCC_SMALL_GAP_HI 4'h7
`define ADCC_FULL_SCALE 10'h3ff
`define ADCC_CONV_BITS 5'd11
`endif

// file: verilog/adcc_pkg.sv
// types of the converter control block
package adcc_pkg;
   typedef enum logic [1:0] {
      ADCC_IDLE = 2'b00,
      ADCC_ACQ = 2'b01,
      ADCC_CONV = 2'b10
   } adcc_state_t;
   typedef struct packed {
      logic [3:0] channel;
      logic start;
   } adcc_req_t;
endpackage : adcc_pkg

// file: verilog/adcc_top.sv
// converter control, channel select and register bank
`timescale 1ns/1ns
`default_nettype none
`include "adcc_cfg.svh"

module adcc_top
   import adcc_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b1
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // converter core
   output logic [10:0] channel_onehot,
   output logic [10:0] pin_analog,
   output logic converter_power,
   input wire logic comparator_high,
   // interrupt
   output logic irq
);

   // ------------------------------------------------------------
   // register bank
   // ------------------------------------------------------------
   logic [7:0] converter_control_0;
   logic [7:0] converter_port_config;
   logic [7:0] converter_timing_config;
   logic [9:0] result;
   logic conversion_complete_flag;
   logic irq_mask;
   logic done_pulse;
   adcc_state_t state;
   adcc_state_t next_state;
   adcc_req_t req;
   logic [4:0] bit_count;
   logic [9:0] sar;
   logic [3:0] tick_count;
   logic tick;
   logic [3:0] acq_count;

   function automatic logic chan_valid(input logic [3:0] c);
      if (c > `ADCC_CHAN_LAST) begin
         chan_valid = 1'b0;
      end else if (!LARGE_VARIANT && c >= `ADCC_SMALL_GAP_LO &&
                   c <= `ADCC_SMALL_GAP_HI) begin
         chan_valid = 1'b0;
      end else begin
         chan_valid = 1'b1;
      end
   endfunction : chan_valid

   wire logic wr = psel && penable && pwrite;
   wire logic mapped = paddr == `ADCC_OFF_RES_HIGH ||
      paddr == `ADCC_OFF_RES_LOW || paddr == `ADCC_OFF_CTRL0 ||
      paddr == `ADCC_OFF_PORT_CFG || paddr == `ADCC_OFF_TIMING_CFG ||
      paddr == `ADCC_OFF_IRQ_STATUS || paddr == `ADCC_OFF_IRQ_MASK;
   // one write strobe per writable register
   wire logic wr_ctrl0 = wr && paddr == `ADCC_OFF_CTRL0;
   wire logic wr_port_cfg = wr && paddr == `ADCC_OFF_PORT_CFG;
   wire logic wr_timing_cfg = wr && paddr == `ADCC_OFF_TIMING_CFG;
   wire logic wr_irq_status = wr && paddr == `ADCC_OFF_IRQ_STATUS;
   wire logic wr_irq_mask = wr && paddr == `ADCC_OFF_IRQ_MASK;

   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign req.channel = converter_control_0[`ADCC_CHS_MSB:`ADCC_CHS_LSB];
   assign req.start = wr_ctrl0 &&
      pwdata[`ADCC_BIT_GO] && pwdata[`ADCC_BIT_ENABLE] &&
      state == ADCC_IDLE;

   // control 0: go cleared by hardware on completion
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         converter_control_0 <= `ADCC_CTRL0_RESET;
      end else if (wr_ctrl0) begin
         // a completion in the same cycle still clears go
         converter_control_0 <= {2'b00, pwdata[5:2],
            req.start || (converter_control_0[`ADCC_BIT_GO] &&
            pwdata[`ADCC_BIT_ENABLE] && !done_pulse),
            pwdata[`ADCC_BIT_ENABLE]};
      end else if (done_pulse || !converter_control_0[`ADCC_BIT_ENABLE]) begin
         converter_control_0[`ADCC_BIT_GO] <= 1'b0;
      end
   end

   // pin modes
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         converter_port_config <= `ADCC_PORT_CFG_RESET;
      end else if (wr_port_cfg) begin
         converter_port_config <= pwdata[7:0];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         converter_timing_config <= `ADCC_TIMING_CFG_RESET;
      end else if (wr_timing_cfg) begin
         converter_timing_config <= pwdata[7:0];
      end
   end

   // interrupt mask, one bit like the status word
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask <= 1'b0;
      end else if (wr_irq_mask) begin
         irq_mask <= pwdata[0];
      end
   end

   // completion flag: set wins over write-one-to-clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         conversion_complete_flag <= 1'b0;
      end else if (done_pulse) begin
         conversion_complete_flag <= 1'b1;
      end else if (wr_irq_status && pwdata[0]) begin
         conversion_complete_flag <= 1'b0;
      end
   end

   assign irq = conversion_complete_flag && irq_mask;

   // ------------------------------------------------------------
   // conversion clock divider and acquisition
   // ------------------------------------------------------------
   wire logic [2:0] clk_sel = converter_timing_config[`ADCC_TIMING_CLK_MSB:
      `ADCC_TIMING_CLK_LSB];
   wire logic [2:0] acq_sel = converter_timing_config[`ADCC_TIMING_ACQ_MSB:
      `ADCC_TIMING_ACQ_LSB];

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tick_count <= 4'h0;
      end else if (state == ADCC_IDLE || tick) begin
         tick_count <= 4'h0;
      end else begin
         tick_count <= tick_count + 4'h1;
      end
   end
   // conversion clock period is 2^clk_sel[1:0] cycles; clk_sel bit 2 is not used
   assign tick = tick_count >= ((4'h1 << clk_sel[1:0]) - 4'h1);

   // ------------------------------------------------------------
   // successive approximation sequencer
   // ------------------------------------------------------------
   wire logic enabled = converter_control_0[`ADCC_BIT_ENABLE];
   wire logic acq_done = state == ADCC_ACQ && tick && acq_count == 4'h0;
   wire logic conv_last = state == ADCC_CONV && tick && bit_count == 5'd1 &&
      enabled;

   // dropping enable ends any conversion without a result
   always_comb begin
      next_state = state;
      case (state)
         ADCC_IDLE: begin
            if (req.start) begin
               next_state = ADCC_ACQ;
            end
         end
         ADCC_ACQ: begin
            if (!enabled) begin
               next_state = ADCC_IDLE;
            end else if (acq_done) begin
               next_state = ADCC_CONV;
            end
         end
         ADCC_CONV: begin
            if (!enabled || conv_last) begin
               next_state = ADCC_IDLE;
            end
         end
         default: begin
            next_state = ADCC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= ADCC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // acquisition ticks left before the first decision
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         acq_count <= 4'h0;
      end else if (req.start) begin
         acq_count <= {1'b0, acq_sel};
      end else if (state == ADCC_ACQ && tick && acq_count != 4'h0) begin
         acq_count <= acq_count - 4'h1;
      end
   end

   // eleven ticks: one settle, then ten decisions
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bit_count <= 5'd0;
      end else if (acq_done) begin
         bit_count <= `ADCC_CONV_BITS;
      end else if (state == ADCC_CONV && tick) begin
         bit_count <= bit_count - 5'd1;
      end
   end

   // one comparator decision per tick, msb first
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sar <= 10'h000;
      end else if (req.start) begin
         sar <= 10'h000;
      end else if (state == ADCC_CONV && tick && bit_count <= 5'd10) begin
         sar[bit_count[3:0] - 4'h1] <= comparator_high;
      end
   end

   // the last decision goes straight into the result
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         result <= 10'h000;
      end else if (conv_last) begin
         result <= chan_valid(req.channel) ?
            {sar[9:1], comparator_high} : `ADCC_FULL_SCALE;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         done_pulse <= 1'b0;
      end else begin
         done_pulse <= conv_last;
      end
   end

   always_comb begin
      channel_onehot = 11'h000;
      if (chan_valid(req.channel) && state != ADCC_IDLE && enabled) begin
         channel_onehot[req.channel] = 1'b1;
      end
   end
   // upper three pins have no config bit and stay analog
   assign pin_analog = ~{3'b000, converter_port_config} & 11'h7ff;
   assign converter_power = converter_control_0[`ADCC_BIT_ENABLE];

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   wire logic just = converter_timing_config[`ADCC_TIMING_JUSTIFY];
   wire logic [15:0] aligned = just ? {6'h00, result} : {result, 6'h00};

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         if (paddr == `ADCC_OFF_RES_HIGH) begin
            prdata <= {24'h0, aligned[15:8]};
         end else if (paddr == `ADCC_OFF_RES_LOW) begin
            prdata <= {24'h0, aligned[7:0]};
         end else if (paddr == `ADCC_OFF_CTRL0) begin
            prdata <= {24'h0, converter_control_0};
         end else if (paddr == `ADCC_OFF_PORT_CFG) begin
            prdata <= {24'h0, converter_port_config};
         end else if (paddr == `ADCC_OFF_TIMING_CFG) begin
            prdata <= {24'h0, converter_timing_config};
         end else if (paddr == `ADCC_OFF_IRQ_STATUS) begin
            prdata <= {31'h0, conversion_complete_flag};
         end else if (paddr == `ADCC_OFF_IRQ_MASK) begin
            prdata <= {31'h0, irq_mask};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

endmodule : adcc_top
`default_nettype wire

// file: test/adcc_properties.sv
// port assertions of the converter control block
`timescale 1ns/1ns
`default_nettype none
`include "adcc_cfg.svh"
module adcc_properties (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // apb side
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   // converter side
   input wire logic [10:0] channel_onehot,
   input wire logic [10:0] pin_analog,
   input wire logic converter_power,
   input wire logic comparator_high,
   input wire logic irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic acc, wr0;
   assign acc = psel && penable;
   assign wr0 = acc && pwrite && paddr == `ADCC_OFF_CTRL0;
   a_ready_always: assert property (acc |-> pready)
      else $error("ready low in access");
   a_slverr_unmapped: assert property
      (acc && paddr > `ADCC_OFF_IRQ_MASK |-> pslverr) else $error("no slverr");
   a_onehot_chan: assert property ($onehot0(channel_onehot))
      else $error("two channels selected");
   a_power_bit: assert property
      (wr0 |=> converter_power == $past(pwdata[0])) else $error("power bit");
   a_off_quiet: assert property
      (!converter_power |-> channel_onehot == 11'h0) else $error("off but on");
   a_unused_none: assert property (wr0 && pwdata[1:0] == 2'b11 &&
      pwdata[5:2] > `ADCC_CHAN_LAST && channel_onehot == 11'h0
      |=> (channel_onehot == 11'h0) [*4]) else $error("unused code selects");
   a_start_chan: assert property (wr0 && pwdata[5:0] == 6'h03 &&
      channel_onehot == 11'h0 |-> ##[1:3] channel_onehot == 11'h001)
      else $error("channel 0 not selected");
   a_top_zero: assert property
      (acc && !pwrite && paddr == `ADCC_OFF_CTRL0 |-> prdata[7:6] == 2'b00)
      else $error("top bits not zero");
   a_irq_sticky: assert property (irq &&
      !(acc && pwrite && paddr >= `ADCC_OFF_IRQ_STATUS) |=> irq)
      else $error("irq dropped");
endmodule : adcc_properties
`default_nettype wire

// file: test/adcc_core_model.sv
// analog core stand-in: odd inputs sit high, idle line wanders
`timescale 1ns/1ns
`default_nettype none
module adcc_core_model (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [10:0] channel_onehot,
   input wire logic converter_power,
   output logic comparator_high
);
   logic [3:0] tick;
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n) tick <= 4'h0;
      else tick <= tick + 4'h1;
   always_comb comparator_high = (|channel_onehot) ?
      |(channel_onehot & 11'h2aa) : tick[0] ^ converter_power;
endmodule : adcc_core_model
`default_nettype wire

// file: test/testbench.sv
// testbench of the converter control block
`timescale 1ns/1ns
`default_nettype none
`include "adcc_cfg.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
   $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module testbench;
   logic clock, rst_n, psel, penable, pwrite, pready, pslverr, e;
   logic converter_power, comparator_high, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [10:0] channel_onehot, pin_analog;
   int n_errors, cmp_count, cycles;
   adcc_top #(.LARGE_VARIANT(1'b1)) uut (.clock, .rst_n, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .channel_onehot,
      .pin_analog, .converter_power, .comparator_high, .irq);
   adcc_core_model core (.clock, .rst_n, .channel_onehot, .converter_power,
      .comparator_high);
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   task automatic tally_and_finish;
      $display("errors %0d, compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : tally_and_finish
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic t_reset;
      for (int i = 0; i < 7; i++) begin
         apb(1'b0, 12'(i * 4), 32'h0);
         `CHK(r, 32'h0)
      end
      `CHK(pin_analog, 11'h7ff)
   endtask : t_reset
   task automatic t_ctrl;
      apb(1'b1, `ADCC_OFF_CTRL0, 32'hfd);
      apb(1'b0, `ADCC_OFF_CTRL0, 32'h0);
      `CHK(r, 32'h3d)
      `CHK(converter_power, 1'b1)
      apb(1'b1, `ADCC_OFF_CTRL0, 32'h02);
      repeat (20) @(posedge clock);
      `CHK(channel_onehot, 11'h0)
      `CHK(converter_power, 1'b0)
      apb(1'b1, `ADCC_OFF_PORT_CFG, 32'h0f);
      @(posedge clock);
      `CHK(pin_analog[7:0], 8'hf0)
   endtask : t_ctrl
   task automatic t_convert(input logic [3:0] code);
      logic m, full;
      m = code != 4'hf;
      apb(1'b1, `ADCC_OFF_IRQ_MASK, {31'h0, m});
      apb(1'b1, `ADCC_OFF_CTRL0, {26'h0, code, 2'b11});
      @(posedge clock);
      @(negedge clock);
      `CHK(channel_onehot, code > 4'ha ? 11'h0 : 11'h1 << code)
      `CHK(channel_onehot[10], code == 4'ha)
      apb(1'b0, `ADCC_OFF_CTRL0, 32'h0);
      `CHK(r[1], 1'b1)
      for (int i = 0; i < 50 && r[1]; i++) apb(1'b0, `ADCC_OFF_CTRL0, 32'h0);
      `CHK(r[1], 1'b0)
      `CHK(irq, m)
      apb(1'b0, `ADCC_OFF_IRQ_STATUS, 32'h0);
      `CHK(r[0], 1'b1)
      // odd inputs sit high, unused codes read full scale
      full = code > 4'ha || code[0];
      apb(1'b0, `ADCC_OFF_RES_HIGH, 32'h0);
      `CHK(r, full ? 32'h03 : 32'h00)
      apb(1'b0, `ADCC_OFF_RES_LOW, 32'h0);
      `CHK(r, full ? 32'hff : 32'h00)
      apb(1'b1, `ADCC_OFF_IRQ_STATUS, 32'h1);
      @(posedge clock);
      `CHK(irq, 1'b0)
   endtask : t_convert
   task automatic t_timing;
      int n;
      // acq 2, tick every 2 cycles, left justified, channel 1
      apb(1'b1, `ADCC_OFF_TIMING_CFG, 32'h11);
      apb(1'b1, `ADCC_OFF_CTRL0, 32'h07);
      @(negedge clock);
      n = 0;
      while (channel_onehot != 11'h0 && n < 100) begin
         n++;
         @(negedge clock);
      end
      `CHK(n, 28)
      apb(1'b0, `ADCC_OFF_RES_HIGH, 32'h0);
      `CHK(r, 32'hff)
      apb(1'b0, `ADCC_OFF_RES_LOW, 32'h0);
      `CHK(r, 32'hc0)
      apb(1'b0, `ADCC_OFF_CTRL0, 32'h0);
      `CHK(r, 32'h05)
      // abort in acquisition: no result, no flag
      apb(1'b1, `ADCC_OFF_IRQ_STATUS, 32'h1);
      apb(1'b1, `ADCC_OFF_CTRL0, 32'h07);
      apb(1'b1, `ADCC_OFF_CTRL0, 32'h04);
      @(negedge clock);
      `CHK(channel_onehot, 11'h0)
      repeat (40) @(posedge clock);
      apb(1'b0, `ADCC_OFF_IRQ_STATUS, 32'h0);
      `CHK(r, 32'h0)
      apb(1'b0, `ADCC_OFF_CTRL0, 32'h0);
      `CHK(r, 32'h04)
   endtask : t_timing
   task automatic t_unmapped;
      apb(1'b1, 12'h01c, 32'hff);
      `CHK(e, 1'b1)
      apb(1'b0, 12'h01c, 32'h0);
      `CHK(r, 32'h0)
   endtask : t_unmapped
   initial begin
      rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h0; pwdata = 32'h0;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      t_reset();
      t_ctrl();
      apb(1'b1, `ADCC_OFF_TIMING_CFG, 32'h80);
      for (int c = 0; c < 16; c++) t_convert(4'(c));
      t_timing();
      t_unmapped();
      tally_and_finish();
   end
endmodule : testbench
bind adcc_top adcc_properties chk (.clock, .rst_n, .psel, .penable, .pwrite,
   .pready, .pslverr, .paddr, .pwdata, .prdata, .channel_onehot, .pin_analog,
   .converter_power, .comparator_high, .irq);
`default_nettype wire
